// *** test/pulse_source.sv ***
// Model of the pulse source wired to the external count pin.
// Assumes the bench calls its task just after a falling clock edge.
`timescale 1ns/100ps

module pulse_source
(
   input wire logic clock,
   output logic pin
);
   // Pin idles low until the bench asks for an edge
   initial
   begin
      pin = 1'b0;
   end

   // minimum widths
   // Levels are held whole clocks; callers never ask for fewer than two
   task automatic level(input logic v, input int hold);
      pin = v;
      repeat (hold) @(negedge clock);
   endtask
endmodule

// *** test/tb_timer0_core.sv ***
// Bench for the timer core: register strobes, count pin, watchdog ticks.
// Assumes one 25 MHz clock and inputs changed on the falling edge.
`timescale 1ns/100ps
`include "timer0_defs.svh"

module tb_timer0_core;
   logic clock, resetn, reg_we, option_we, clear_watchdog_cmd, watchdog_tick;
   logic [7:0] reg_addr, reg_wdata, option_wdata, timer_count, a;
   logic ext_count_input, watchdog_postscaled_tick;
   logic weak_pullup_disable, pin_change_wake_disable;
   int bad_count = 0;
   int check_count = 0;
   int ticks = 0;

   timer0_core timer0_core_inst (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_we(reg_we), .reg_wdata(reg_wdata), .option_we(option_we),
      .option_wdata(option_wdata), .clear_watchdog_cmd(clear_watchdog_cmd),
      .watchdog_tick(watchdog_tick), .ext_count_input(ext_count_input),
      .timer_count(timer_count), .watchdog_postscaled_tick(watchdog_postscaled_tick),
      .weak_pullup_disable(weak_pullup_disable),
      .pin_change_wake_disable(pin_change_wake_disable));
   pulse_source pulse_source_inst (.clock(clock), .pin(ext_count_input));

   // 40 ns clock
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Postscaled ticks are single-cycle pulses; count them where they settle
   always @(negedge clock)
   begin
      if (watchdog_postscaled_tick === 1'b1)
         ticks++;
   end

   task automatic give_verdict();
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic clk(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      reg_addr = ad;
      reg_wdata = d;
      reg_we = 1'b1;
      clk(1);
      reg_we = 1'b0;
   endtask

   task automatic opt(input logic [7:0] d);
      option_wdata = d;
      option_we = 1'b1;
      clk(1);
      option_we = 1'b0;
   endtask

   task automatic wd();
      watchdog_tick = 1'b1;
      clk(1);
      watchdog_tick = 1'b0;
      clk(1);
   endtask

   task automatic clr();
      clear_watchdog_cmd = 1'b1;
      clk(1);
      clear_watchdog_cmd = 1'b0;
      clk(1);
   endtask

   // Steady rate: n increments in n periods, once the first one has passed
   task automatic rate(input int per, input int n);
      clk(per + 16);
      a = timer_count;
      clk(per * n);
      check(timer_count - a, 8'(n));
   endtask

   // Main sequence
   initial
   begin
      resetn = 1'b0;
      reg_we = 1'b0;
      option_we = 1'b0;
      clear_watchdog_cmd = 1'b0;
      watchdog_tick = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      option_wdata = 8'h00;
      clk(4);
      resetn = 1'b1;
      clk(1);
      check(timer_count, 8'h00);
      check({6'h00, pin_change_wake_disable, weak_pullup_disable}, 8'h03);
      // Counter mode with a quiet pin freezes the count for register tests
      opt(8'h3f);
      check({6'h00, pin_change_wake_disable, weak_pullup_disable}, 8'h00);
      wr(`T0_COUNT_OFFSET, 8'h5a);
      check(timer_count, 8'h5a);
      clk(1);
      wr(8'h02, 8'h11);
      clk(1);
      check(timer_count, 8'h5a);
      opt(8'h08);
      wr(`T0_COUNT_OFFSET, 8'hf0);
      clk(8);
      check(timer_count, 8'hf0);
      rate(4, 10);
      for (int n = 0; n < 8; n++)
      begin
         clr();
         opt({5'h00, 3'(n)});
         wr(`T0_COUNT_OFFSET, 8'h00);
         rate(8 << n, 4);
      end
      // At 1:256 the first increment needs 512 clocks unless cleared again
      wr(`T0_COUNT_OFFSET, 8'h00);
      clk(400);
      wr(`T0_COUNT_OFFSET, 8'h00);
      clk(400);
      check(timer_count, 8'h00);
      opt(8'h20);
      wr(`T0_COUNT_OFFSET, 8'h00);
      // Let the post-write hold-off expire so no pin edge is swallowed
      clk(8);
      repeat (4)
      begin
         pulse_source_inst.level(1'b1, 4);
         pulse_source_inst.level(1'b0, 4);
      end
      clk(16);
      check(timer_count, 8'h02);
      clr();
      wr(`T0_COUNT_OFFSET, 8'h00);
      opt(8'h2f);
      clr();
      opt(8'h28);
      pulse_source_inst.level(1'b1, 2);
      check(timer_count, 8'h00);
      clk(14);
      check(timer_count, 8'h01);
      // Edge select flips only while high, so no false edge appears
      opt(8'h38);
      pulse_source_inst.level(1'b0, 16);
      check(timer_count, 8'h02);
      pulse_source_inst.level(1'b1, 16);
      check(timer_count, 8'h02);
      opt(8'h09);
      clr();
      ticks = 0;
      wd();
      clr();
      wd();
      clk(4);
      check(8'(ticks), 8'h00);
      wd();
      clk(4);
      check(8'(ticks), 8'h01);
      wd();
      resetn = 1'b0;
      clk(2);
      resetn = 1'b1;
      clk(1);
      opt(8'h09);
      wd();
      wd();
      clk(4);
      check(8'(ticks), 8'h02);
      give_verdict();
   end

   // Run needs about 11k clocks; 2 ms is ample
   initial
   begin
      #2000000;
      bad_count++;
      give_verdict();
   end
endmodule

// *** verilog/prescale_counter.sv ***
// Free-running prescaler counter shared between the timer and the watchdog.
// Assumes advance and clear are single-cycle strobes on the same clock.
`timescale 1ns/100ps
`include "timer0_defs.svh"

module prescale_counter
#(
   parameter int WIDTH = `T0_PRESCALE_WIDTH
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clear,
   input wire logic advance,
   output logic [WIDTH-1:0] count
);

   logic [WIDTH-1:0] count_next;

   // No load path exists: only reset, clear or advance can change the count
   assign count_next = clear ? '0 : (advance ? count + 1'b1 : count);

   // Reset and clear both empty the counter
   always_ff @(posedge clock)
   begin
      if (!resetn)
         count <= '0;
      else
         count <= count_next;
   end

endmodule

// *** verilog/timer0_core.sv ***
// 8-bit timer/counter with an 8-bit prescaler shared with the watchdog.
// Assumes clock is the oscillator (Tosc) and core strobes share its domain;
// the external count pin is asynchronous and is synchronised here.
`timescale 1ns/100ps
`include "timer0_defs.svh"

// Operation
// RQ1: Source bit 0: count instruction cycles
// RQ2: Count write blocks increments two cycles
// RQ3: Source bit 1: count external pin edges
// RQ4: Edge bit 0 rising, 1 falling
// RQ5: Prescaler serves timer or watchdog only
// RQ6: Ratio selects divide-by-2 through 256
// RQ7: Ratio n divides by 2^(n+1); else 1:1 (code gives no watchdog tick at all when the prescaler is with the timer)
// RQ8: Prescaler 8 bits, no software access
// RQ9: Count writes clear prescaler when assigned
// RQ10: Clear-watchdog clears prescaler when assigned
// RQ11: Reset zeroes the prescaler
// RQ12: Pin goes through prescaler unless bypassed
// RQ13: Prescaler output sampled at Q2, Q4
// RQ14: Pin high and low two Tosc minimum
// RQ15: Prescaled pin period four Tosc over ratio
// RQ16: Increment three to seven Tosc after edge
// RQ17: Software sequence for timer to watchdog
// RQ18: Clear watchdog before watchdog to timer
// RQ19: Count register 8 bits, read/write
module timer0_core
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_we,
   input wire logic [7:0] reg_wdata,
   input wire logic option_we,
   input wire logic [7:0] option_wdata,
   input wire logic clear_watchdog_cmd,
   input wire logic watchdog_tick,
   input wire logic ext_count_input,
   output logic [7:0] timer_count,
   output logic watchdog_postscaled_tick,
   output logic weak_pullup_disable,
   output logic pin_change_wake_disable
);

   timer0_pkg::phase_t phase_reg;
   timer0_pkg::phase_t phase_next;
   logic [7:0] option_reg;
   logic [7:0] timer_count_reg;
   logic [7:0] timer_count_next;
   logic [1:0] inhibit_reg;
   logic [1:0] inhibit_next;
   logic ext_meta_reg;
   logic ext_sync_reg;
   logic ext_prev_reg;
   logic sample_q2_reg;
   logic sample_q4_reg;
   logic wd_prev_reg;
   logic wd_tick_reg;
   logic [`T0_PRESCALE_WIDTH-1:0] prescale_count;

   // Phase decode: one-cycle enables for Q2 and Q4
   wire q2 = (phase_reg == timer0_pkg::PHASE_Q2);
   wire q4 = (phase_reg == timer0_pkg::PHASE_Q4);

   // Control fields
   wire count_source_select = option_reg[`T0_SRC_SEL_BIT];
   wire count_edge_select = option_reg[`T0_EDGE_SEL_BIT];
   wire prescaler_assign = option_reg[`T0_ASSIGN_BIT];
   wire [2:0] prescale_ratio = option_reg[`T0_RATIO_HI:`T0_RATIO_LO];
   wire count_we = reg_we && (reg_addr == `T0_COUNT_OFFSET);

   // Rising edge of the polarity-adjusted pin; falling edges invert first
   // RQ4 edge polarity
   wire ext_level = ext_sync_reg ^ count_edge_select;
   wire ext_prev_level = ext_prev_reg ^ count_edge_select;
   wire ext_edge = ext_level && !ext_prev_level;

   // Prescaler input: watchdog ticks, pin edges or instruction cycles
   // RQ3 pin count source
   // RQ5 single user
   wire prescale_advance = prescaler_assign ? watchdog_tick
                         : (count_source_select ? ext_edge : q4);
   // RQ9 write clears
   wire clear_by_write = count_we && !prescaler_assign;
   // RQ10 watchdog clear
   wire clear_by_wd = clear_watchdog_cmd && prescaler_assign;
   wire prescale_clear = clear_by_write || clear_by_wd;

   // Bit n of the prescaler toggles at input/2^(n+1) rate
   // RQ6 ratio select
   wire prescale_tap = prescale_count[prescale_ratio];

   // Level fed to the Q2/Q4 sampler; the pin bypasses the divider when
   // the prescaler belongs to the watchdog. Pin is already synchronised,
   // which costs up to two Tosc over an analogue sampler.
   // RQ12 divider or bypass
   wire sync_source = prescaler_assign ? ext_level : prescale_tap;

   // Counter mode or prescaled timer: a rise seen at Q2 (against the last Q4
   // sample) or at this Q4 (against the Q2 sample) counts once, at Q4.
   // Timer without prescaler counts every instruction cycle.
   // RQ1 timer mode
   wire timer_direct = !count_source_select && prescaler_assign;
   wire rise_at_q2 = sample_q2_reg && !sample_q4_reg;
   wire rise_at_q4 = sync_source && !sample_q2_reg;
   wire sampled_rise = q4 && (rise_at_q2 || rise_at_q4);
   wire count_event = timer_direct ? q4 : sampled_rise;
   wire count_inc = count_event && (inhibit_reg == 2'h0);

   // Count register: a write wins over an increment
   assign timer_count_next = count_we ? reg_wdata
                           : (count_inc ? timer_count_reg + 8'h01 : timer_count_reg);

   // RQ2 write inhibit
   assign inhibit_next = count_we ? `T0_INHIBIT_CYCLES
                       : ((q4 && inhibit_reg != 2'h0) ? inhibit_reg - 2'h1 : inhibit_reg);

   // Phase sequencer divides the oscillator into four phases
   always_comb
   begin
      case (phase_reg)
         timer0_pkg::PHASE_Q1: phase_next = timer0_pkg::PHASE_Q2;
         timer0_pkg::PHASE_Q2: phase_next = timer0_pkg::PHASE_Q3;
         timer0_pkg::PHASE_Q3: phase_next = timer0_pkg::PHASE_Q4;
         default: phase_next = timer0_pkg::PHASE_Q1;
      endcase
   end

   // Phase, control and count registers
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         phase_reg <= timer0_pkg::PHASE_Q1;
         option_reg <= `T0_OPTION_RESET;
         timer_count_reg <= 8'h00;
         inhibit_reg <= 2'h0;
      end
      else
      begin
         phase_reg <= phase_next;
         if (option_we)
            option_reg <= option_wdata;
         // RQ19 count register
         timer_count_reg <= timer_count_next;
         inhibit_reg <= inhibit_next;
      end
   end

   // Pin synchroniser; only ext_sync_reg and ext_prev_reg are read by logic
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end
      else
      begin
         ext_meta_reg <= ext_count_input;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end

   // Phase sampler: the source is sampled at both Q2 and Q4, so a level that
   // lasts two oscillator periods is always caught by one of them.
   // Samplers start high so a level already high at release is no edge.
   // RQ13 Q2 Q4 sampling
   // RQ16 edge latency
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         sample_q2_reg <= 1'b1;
         sample_q4_reg <= 1'b1;
      end
      else
      begin
         if (q2)
            sample_q2_reg <= sync_source;
         if (q4)
            sample_q4_reg <= sync_source;
      end
   end

   // Watchdog postscaler output: one pulse per rise of the selected tap while the prescaler is assigned to the watchdog
   // RQ7 watchdog postscale
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         wd_prev_reg <= 1'b0;
         wd_tick_reg <= 1'b0;
      end
      else
      begin
         wd_prev_reg <= prescale_tap;
         wd_tick_reg <= prescaler_assign && prescale_tap && !wd_prev_reg;
      end
   end

   // RQ8 shared prescaler
   // RQ11 reset clear
   prescale_counter #(.WIDTH(`T0_PRESCALE_WIDTH)) prescaler
   (
      .clock(clock),
      .resetn(resetn),
      .clear(prescale_clear),
      .advance(prescale_advance),
      .count(prescale_count)
   );

   assign timer_count = timer_count_reg;
   assign watchdog_postscaled_tick = wd_tick_reg;
   assign weak_pullup_disable = option_reg[`T0_PULLUP_DIS_BIT];
   assign pin_change_wake_disable = option_reg[`T0_WAKE_DIS_BIT];

   // Checks on the counting behaviour
   property p_write_holds;
      @(posedge clock) disable iff (!resetn)
      (count_we ##1 (!count_we)[*4]) |-> (timer_count_reg == $past(reg_wdata, 4));
   endproperty
   a_write_holds: assert property (p_write_holds) else $error("count changed after write"); // RQ2

   property p_inhibit_set;
      @(posedge clock) disable iff (!resetn)
      count_we |=> (inhibit_reg == 2'h2) && !count_inc;
   endproperty
   a_inhibit_set: assert property (p_inhibit_set) else $error("inhibit not armed"); // RQ2

   property p_direct_timer;
      @(posedge clock) disable iff (!resetn)
      (q4 && timer_direct && inhibit_reg == 2'h0 && !count_we && !option_we)
         |=> timer_count_reg == $past(timer_count_reg) + 8'h01;
   endproperty
   a_direct_timer: assert property (p_direct_timer) else $error("timer missed cycle"); // RQ1

   property p_inc_at_q4;
      @(posedge clock) disable iff (!resetn)
      count_inc |-> q4;
   endproperty
   a_inc_at_q4: assert property (p_inc_at_q4) else $error("increment off Q4"); // RQ13

   property p_write_clear;
      @(posedge clock) disable iff (!resetn)
      (count_we && !prescaler_assign) |=> prescale_count == `T0_PRESCALE_CLEAR;
   endproperty
   a_write_clear: assert property (p_write_clear) else $error("prescaler not cleared"); // RQ9

   property p_wd_clear;
      @(posedge clock) disable iff (!resetn)
      (clear_watchdog_cmd && prescaler_assign) |=> prescale_count == `T0_PRESCALE_CLEAR;
   endproperty
   a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear missed"); // RQ10

   property p_reset_zero;
      @(posedge clock) disable iff (!resetn)
      $rose(resetn) |-> prescale_count == `T0_PRESCALE_CLEAR;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("prescaler not zero"); // RQ11

   property p_presc_step;
      @(posedge clock) disable iff (!resetn)
      !$stable(prescale_count) |-> (prescale_count == $past(prescale_count) + 8'h01)
         || (prescale_count == `T0_PRESCALE_CLEAR);
   endproperty
   a_presc_step: assert property (p_presc_step) else $error("prescaler jumped"); // RQ8

   property p_pin_edge_count;
      @(posedge clock) disable iff (!resetn)
      (count_source_select && prescaler_assign && ext_edge && inhibit_reg == 2'h0
         && !count_we && !option_we) ##1 (!count_we && !option_we)[*7]
         |-> timer_count_reg != $past(timer_count_reg, 8);
   endproperty
   a_pin_edge_count: assert property (p_pin_edge_count) else $error("edge not counted"); // RQ3

   c_timer: cover property (@(posedge clock) disable iff (!resetn) timer_direct && count_inc);
   c_pin: cover property (@(posedge clock) disable iff (!resetn)
      count_source_select && count_inc);
   c_presc: cover property (@(posedge clock) disable iff (!resetn)
      !prescaler_assign && sampled_rise);
   c_wd: cover property (@(posedge clock) disable iff (!resetn) wd_tick_reg);

endmodule

// *** verilog/timer0_defs.svh ***
// Constants for the instruction-cycle timer with shared prescaler.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef TIMER0_DEFS_SVH
`define TIMER0_DEFS_SVH

// Register map: the count register has an address, the control register
// is loaded by its own instruction strobe and has none
`define T0_COUNT_OFFSET 8'h01
`define T0_OPTION_RESET 8'hff

// Field positions inside the control register
`define T0_WAKE_DIS_BIT 7
`define T0_PULLUP_DIS_BIT 6
`define T0_SRC_SEL_BIT 5
`define T0_EDGE_SEL_BIT 4
`define T0_ASSIGN_BIT 3
`define T0_RATIO_HI 2
`define T0_RATIO_LO 0

// Instruction cycles with increments held off after a count write
`define T0_INHIBIT_CYCLES 2'h2

// Prescaler width and cleared value
`define T0_PRESCALE_WIDTH 8
`define T0_PRESCALE_CLEAR 8'h00

`endif

// *** verilog/timer0_pkg.sv ***
// Types shared by the timer design files.
// Assumes nothing of its surroundings.
package timer0_pkg;

   // Four oscillator periods make one instruction cycle
   typedef enum logic [1:0] {PHASE_Q1, PHASE_Q2, PHASE_Q3, PHASE_Q4} phase_t;

endpackage
